//--- pkg/state_defines.vh
// Purpose: Constants for the processor state register block
// Assumes: Bits numbered 0 = msb (big-endian); vector index = 31 - bit
// Notes on behaviour
// [R1] User cache locking blocked when lock enable clear; data storage int, lock flag set.
// [R2] Sleep allow clear blocks power saving; set allows state chosen by hw_config0.
// [R3] Critical enable gates critical input and watchdog interrupts.
// [R4] External enable gates external, decrementer and fixed-interval interrupts.
// [R5] User mode set refuses privileged instructions and resources.
// [R6] Float avail clear: any float instruction raises float-unavailable interrupt.
// [R7] Float avail set: float instruction raises unimplemented-operation program exception.
// [R8] Machine check enable gates machine check interrupts.
// [R9] Debug allow gates debug interrupts.
// [R10] Both float exception mode bits have no effect on behaviour.
// [R11] Reserved bits and the vector-extension bit have no effect.
// [R12] Unimplemented reserved bits read zero; writes to them discarded.
// [R13] Taking an interrupt copies the state register into the class save register.
// [R14] State register write in user mode refused with privileged program exception.
`ifndef STATE_DEFINES_VH
`define STATE_DEFINES_VH

// Vector indices (31 - architectural bit number)
`define USER_LOCK_EN_IDX 26
`define SLEEP_ALLOW_IDX 18
`define CRIT_EN_IDX 17
`define EXT_EN_IDX 15
`define USER_MODE_IDX 14
`define FLOAT_AVAIL_IDX 13
`define MCHECK_EN_IDX 12
`define FPEXC_MODE0_IDX 11
`define DBG_ALLOW_IDX 9
`define FPEXC_MODE1_IDX 8
`define INSTR_SPACE_IDX 5
`define DATA_SPACE_IDX 4

// Implemented bits: 5,13,14,16..20,22,23,26,27 (bit 6 allocated, not kept)
`define MS_IMPL_MASK 32'h0406_fb30
`define MS_RESET 32'h0000_0000

// Interrupt classes for save-register selection
`define CLS_NONCRIT 2'h0
`define CLS_CRIT 2'h1
`define CLS_DEBUG 2'h2

// Taken interrupt source codes
`define SRC_NONE 3'h0
`define SRC_EXT 3'h1
`define SRC_CRIT 3'h2
`define SRC_MCHK 3'h3
`define SRC_DBG 3'h4

// Power state shown while no saving state is entered
`define PM_NONE 3'h0

`endif

//--- rtl/processor_state_control.v
// Purpose: Processor state register with interrupt gating and trap decisions
// Assumes: Requests come from the core pipeline on the same clock
// Notes: Outputs are registered, so decisions appear one cycle after request
`timescale 1ns/1ps
`include "state_defines.vh"

module processor_state_control (
    // Clock and reset
    input wire clock,
    input wire rst,
    // Software write / read
    input wire wr_req,
    input wire [31:0] wr_data,
    output reg [31:0] rd_data_q,
    output reg priv_exc_q,
    // Interrupt requests
    input wire crit_in_req,
    input wire watchdog_req,
    input wire ext_in_req,
    input wire dec_req,
    input wire fit_req,
    input wire mcheck_req,
    input wire debug_req,
    // Instruction checks
    input wire priv_instr,
    input wire float_instr,
    input wire cache_lock_instr,
    input wire cache_lock_is_instr,
    // Return from interrupt
    input wire rfi_req,
    input wire [1:0] rfi_class,
    // Power
    input wire power_cond,
    input wire [2:0] pm_select,
    // Results
    output reg [2:0] take_int_q,
    output reg [1:0] take_class_q,
    output reg fp_unavail_q,
    output reg unimpl_op_q,
    output reg dsi_q,
    output reg instr_lock_flag_q,
    output reg data_lock_flag_q,
    output reg [2:0] power_state_q,
    output reg [31:0] save_state_noncrit_q,
    output reg [31:0] save_state_crit_q,
    output reg [31:0] save_state_debug_q
);

    // State register and its next value, reserved bits kept clear
    reg [31:0] ms_q;
    reg [31:0] ms_d;
    // Winning request of this cycle
    reg [1:0] cls;
    reg take;
    reg [2:0] which;

    function [31:0] restore_src;
        input [1:0] c;
        input [31:0] n, cr, d;
        begin
            case (c)
                `CLS_CRIT: restore_src = cr;
                `CLS_DEBUG: restore_src = d;
                default: restore_src = n;
            endcase
        end
    endfunction

    // Lock check shared by the trap and both syndrome flags
    function lock_refused;
        input lock_instr;
        input user;
        input user_lock_en;
        begin
            lock_refused = lock_instr && user && !user_lock_en;
        end
    endfunction

    // Priority: debug, machine check, critical, external class
    always @*
    begin
        take = 1'b0;
        cls = `CLS_NONCRIT;
        which = `SRC_NONE;
        // [R9] Debug gate
        if (debug_req && ms_q[`DBG_ALLOW_IDX])
        begin
            take = 1'b1;
            cls = `CLS_DEBUG;
            which = `SRC_DBG;
        end
        // [R8] Machine check gate
        else if (mcheck_req && ms_q[`MCHECK_EN_IDX])
        begin
            take = 1'b1;
            cls = `CLS_CRIT;
            which = `SRC_MCHK;
        end
        // [R3] Critical gate
        else if ((crit_in_req || watchdog_req) && ms_q[`CRIT_EN_IDX])
        begin
            take = 1'b1;
            cls = `CLS_CRIT;
            which = `SRC_CRIT;
        end
        // [R4] External gate
        else if ((ext_in_req || dec_req || fit_req) && ms_q[`EXT_EN_IDX])
        begin
            take = 1'b1;
            cls = `CLS_NONCRIT;
            which = `SRC_EXT;
        end
    end

    // Interrupt entry clears nothing here; the core's handler state is beyond this block
    always @*
    begin
        ms_d = ms_q;
        // Return beats a write in the same cycle
        if (rfi_req)
            ms_d = restore_src(rfi_class, save_state_noncrit_q, save_state_crit_q,
                save_state_debug_q) & `MS_IMPL_MASK;
        // [R14] User-mode write refused
        else if (wr_req && !ms_q[`USER_MODE_IDX])
            // [R12] [R11] Reserved and vector bits dropped; [R10] stored only, never used
            ms_d = wr_data & `MS_IMPL_MASK;
    end

    // State register; software sees it one cycle later through rd_data_q
    always @(posedge clock)
    begin
        if (rst)
        begin
            ms_q <= `MS_RESET;
            rd_data_q <= `MS_RESET;
        end
        else
        begin
            ms_q <= ms_d;
            // [R12] Reserved bits read zero
            rd_data_q <= ms_q & `MS_IMPL_MASK;
        end
    end

    // Interrupt decision; source and class stand one cycle per request
    always @(posedge clock)
    begin
        if (rst)
        begin
            take_int_q <= `SRC_NONE;
            take_class_q <= `CLS_NONCRIT;
        end
        else
        begin
            take_int_q <= which;
            take_class_q <= cls;
        end
    end

    // [R13] Save on interrupt
    // Pre-edge state is saved, so a write in the same cycle is not captured
    always @(posedge clock)
    begin
        if (rst)
        begin
            save_state_noncrit_q <= `MS_RESET;
            save_state_crit_q <= `MS_RESET;
            save_state_debug_q <= `MS_RESET;
        end
        else
        begin
            if (take && cls == `CLS_NONCRIT)
                save_state_noncrit_q <= ms_q;
            if (take && cls == `CLS_CRIT)
                save_state_crit_q <= ms_q;
            if (take && cls == `CLS_DEBUG)
                save_state_debug_q <= ms_q;
        end
    end

    // Instruction traps; the core picks the vector, this block only flags
    always @(posedge clock)
    begin
        if (rst)
        begin
            priv_exc_q <= 1'b0;
            fp_unavail_q <= 1'b0;
            unimpl_op_q <= 1'b0;
            dsi_q <= 1'b0;
            instr_lock_flag_q <= 1'b0;
            data_lock_flag_q <= 1'b0;
        end
        else
        begin
            // [R5] [R14] Privilege refusal
            priv_exc_q <= ms_q[`USER_MODE_IDX] && (priv_instr || wr_req);
            // [R6] Float unavailable
            fp_unavail_q <= float_instr && !ms_q[`FLOAT_AVAIL_IDX];
            // [R7] No float hardware
            unimpl_op_q <= float_instr && ms_q[`FLOAT_AVAIL_IDX];
            // [R1] User cache lock check
            dsi_q <= lock_refused(cache_lock_instr, ms_q[`USER_MODE_IDX],
                ms_q[`USER_LOCK_EN_IDX]);
            instr_lock_flag_q <= lock_refused(cache_lock_instr, ms_q[`USER_MODE_IDX],
                ms_q[`USER_LOCK_EN_IDX]) && cache_lock_is_instr;
            data_lock_flag_q <= lock_refused(cache_lock_instr, ms_q[`USER_MODE_IDX],
                ms_q[`USER_LOCK_EN_IDX]) && !cache_lock_is_instr;
        end
    end

    // [R2] Power-saving entry
    // Selection passes through unchecked; the core decodes doze, nap or sleep
    always @(posedge clock)
    begin
        if (rst)
            power_state_q <= `PM_NONE;
        else if (ms_q[`SLEEP_ALLOW_IDX] && power_cond)
            power_state_q <= pm_select;
        else
            power_state_q <= `PM_NONE;
    end

endmodule

//--- verif/state_props.sv
// Purpose: Port checks for the state register block
// Assumes: rd_data_q shows the state that the same cycle's results used
// Notes: Stored mask is written out here, independent of the design
`timescale 1ns/1ps
module state_props (
    // Watched ports
    input wire clock,
    input wire rst,
    input wire wr_req,
    input wire rfi_req,
    input wire ext_in_req,
    input wire dec_req,
    input wire fit_req,
    input wire debug_req,
    input wire float_instr,
    input wire power_cond,
    input wire [2:0] pm_select,
    input wire [31:0] rd_data_q,
    input wire priv_exc_q,
    input wire [2:0] take_int_q,
    input wire fp_unavail_q,
    input wire unimpl_op_q,
    input wire [2:0] power_state_q,
    input wire [31:0] save_state_noncrit_q
);
    wire [31:0] m = rd_data_q;
    reg live_q;
    // Skips the first edge, whose past inputs date from reset
    always @(posedge clock)
        live_q <= !rst;
    default clocking @(posedge clock); endclocking
    default disable iff (rst || !live_q);
    a_ext_take: assert property (take_int_q == 3'h1 |-> m[15] &&
        $past(ext_in_req || dec_req || fit_req)) else $error("external take wrong");
    a_dbg_take: assert property ($past(debug_req) && m[9] |->
        take_int_q == 3'h4) else $error("debug take wrong");
    a_fp_unavail: assert property (
        fp_unavail_q == ($past(float_instr) && !m[13])) else $error("fp unavail wrong");
    a_unimpl_op: assert property (
        unimpl_op_q == ($past(float_instr) && m[13])) else $error("unimpl op wrong");
    a_resv_zero: assert property (
        (m & ~32'h0406fb30) == 32'h0) else $error("reserved bit set");
    a_user_write: assert property ($past(wr_req) && !$past(rfi_req) && m[14] |->
        priv_exc_q ##1 $stable(m)) else $error("user write not refused");
    a_save_copy: assert property (take_int_q == 3'h1 |->
        save_state_noncrit_q == m) else $error("save copy wrong");
    a_power_sel: assert property (power_state_q ==
        (($past(power_cond) && m[18]) ? $past(pm_select) : 3'h0)) else $error("power wrong");
endmodule
bind processor_state_control state_props state_props_inst (.clock(clock), .rst(rst),
    .wr_req(wr_req), .rfi_req(rfi_req), .ext_in_req(ext_in_req), .dec_req(dec_req),
    .fit_req(fit_req), .debug_req(debug_req), .float_instr(float_instr),
    .power_cond(power_cond), .pm_select(pm_select), .rd_data_q(rd_data_q),
    .priv_exc_q(priv_exc_q), .take_int_q(take_int_q), .fp_unavail_q(fp_unavail_q),
    .unimpl_op_q(unimpl_op_q), .power_state_q(power_state_q),
    .save_state_noncrit_q(save_state_noncrit_q));

//--- verif/processor_state_control_test.sv
// Purpose: Self-checking bench for the state register block
// Assumes: Results one cycle after request
// Notes: Rows hold write value, requests and expected results
`timescale 1ns/1ps
module processor_state_control_test;
    localparam logic [31:0] M = 32'h0406fb30;
    logic clock, rst, wr_req;
    logic [31:0] wr_data;
    logic [11:0] i, nx, ex;
    integer failures = 0, checked = 0, cycles = 0, n;
    wire [31:0] rd_data_q;
    wire [2:0] take_int_q, power_state_q;
    wire [1:0] cls;
    wire priv_exc_q, fu, uo, dsi, ilock, dlock;
    wire [11:0] o = {take_int_q, fu, uo, dsi, ilock, dlock, priv_exc_q, power_state_q};
    wire [31:0] sn, sc, sd;
    logic rfi;
    logic [1:0] rc;
    logic [2:0] pm;
    logic [55:0] rows [0:15] = '{56'h00008000_200_200, 56'h00008000_100_200,
        56'h00008000_080_200, 56'h00000000_380_000, 56'h00020000_800_400,
        56'h00020000_400_400, 56'h00008000_c00_000, 56'h00001000_040_600,
        56'h00000000_040_000, 56'h00029200_fe0_800, 56'h00000000_008_100,
        56'h00002900_008_080, 56'h00040000_001_005, 56'h00004000_006_060,
        56'h00004000_004_050, 56'h00004000_010_008};
    processor_state_control processor_state_control_inst (.clock(clock), .rst(rst),
        .wr_req(wr_req), .wr_data(wr_data), .rd_data_q(rd_data_q), .priv_exc_q(priv_exc_q),
        .crit_in_req(i[11]), .watchdog_req(i[10]), .ext_in_req(i[9]), .dec_req(i[8]),
        .fit_req(i[7]), .mcheck_req(i[6]), .debug_req(i[5]), .priv_instr(i[4]),
        .float_instr(i[3]), .cache_lock_instr(i[2]), .cache_lock_is_instr(i[1]),
        .power_cond(i[0]), .rfi_req(rfi), .rfi_class(rc), .pm_select(pm),
        .take_int_q(take_int_q), .take_class_q(cls), .fp_unavail_q(fu), .unimpl_op_q(uo),
        .dsi_q(dsi), .instr_lock_flag_q(ilock), .data_lock_flag_q(dlock),
        .power_state_q(power_state_q), .save_state_noncrit_q(sn), .save_state_crit_q(sc),
        .save_state_debug_q(sd));
    task chk(input [31:0] g, input [31:0] x);
        checked++;
        if (g !== x)
        begin
            $display("wrong value at %0t: got %h expected %h", $time, g, x);
            failures++;
        end
    endtask
    task wrap_up;
        if (failures == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        clock = 0;
        forever #10 clock = ~clock;
    end
    // Cuts a hang short well past the expected length
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 500)
        begin
            failures++;
            wrap_up;
        end
    end
    initial
    begin
        {rst, wr_req, wr_data, i} = {1'b1, 1'b0, 32'h0, 12'h0};
        {rfi, rc, pm} = {1'b0, 2'h0, 3'h5};
        repeat (6) @(negedge clock);
        rst = 0;
        chk(rd_data_q, 32'h0);
        for (n = 0; n < 16; n++)
        begin
            @(negedge clock);
            {wr_data, nx, ex} = rows[n];
            wr_req = 1;
            i = 0;
            @(negedge clock);
            wr_req = 0;
            i = nx;
            @(negedge clock);
            chk(o, ex);
            chk(rd_data_q, wr_data & M);
        end
        wr_data = 0;
        wr_req = 1;
        i = 0;
        @(negedge clock);
        wr_req = 0;
        chk(priv_exc_q, 1);
        @(negedge clock);
        chk(rd_data_q, 32'h4000);
        rst = 1;
        repeat (2) @(negedge clock);
        chk({o, rd_data_q[19:0]}, 32'h0);
        rst = 0;
        wr_data = 32'hffffffff;
        wr_req = 1;
        @(negedge clock);
        wr_req = 0;
        i = 12'h004;
        @(negedge clock);
        chk(rd_data_q, M);
        chk(o, 12'h0);
        // Per-class save, then restore from each save register
        rst = 1;
        i = 0;
        @(negedge clock);
        rst = 0;
        wr_data = 32'h00008000;
        wr_req = 1;
        @(negedge clock);
        wr_req = 0;
        i = 12'h200;
        @(negedge clock);
        chk(cls, 2'h0);
        chk(sn, 32'h00008000);
        i = 0;
        wr_data = 32'h00001000;
        wr_req = 1;
        @(negedge clock);
        wr_req = 0;
        i = 12'h040;
        @(negedge clock);
        chk(cls, 2'h1);
        chk(sc, 32'h00001000);
        i = 0;
        wr_data = 32'h00004200;
        wr_req = 1;
        @(negedge clock);
        wr_req = 0;
        i = 12'h020;
        @(negedge clock);
        chk(cls, 2'h2);
        chk(sd, 32'h00004200);
        i = 0;
        rc = 2'h1;
        rfi = 1;
        @(negedge clock);
        rfi = 0;
        @(negedge clock);
        chk(rd_data_q, 32'h00001000);
        rc = 2'h2;
        rfi = 1;
        @(negedge clock);
        rfi = 0;
        @(negedge clock);
        chk(rd_data_q, 32'h00004200);
        rc = 2'h0;
        rfi = 1;
        @(negedge clock);
        rfi = 0;
        @(negedge clock);
        chk(rd_data_q, 32'h00008000);
        // Second selection value, not symmetric in its bits
        wr_data = 32'h00040000;
        wr_req = 1;
        pm = 3'h6;
        @(negedge clock);
        wr_req = 0;
        i = 12'h001;
        @(negedge clock);
        chk(power_state_q, 3'h6);
        wrap_up;
    end
endmodule
